//--- rtl/lzb_regs.vh
// Purpose: constants for the logic/zero-branch execution slice
// Assumes: big-endian bit numbering of the word, bit 0 is the MSB
// Notes: field positions given as Verilog LSB-0 indices
`ifndef LZB_REGS_VH
`define LZB_REGS_VH

// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define LZB_OPC_HI 31
`define LZB_OPC_LO 26
`define LZB_RD_HI 25
`define LZB_RD_LO 21
`define LZB_RA_HI 20
`define LZB_RA_LO 16
`define LZB_RB_HI 15
`define LZB_RB_LO 11
`define LZB_IMM_HI 15
`define LZB_IMM_LO 0
`define LZB_DBIT 25
`define LZB_COND_HI 23
`define LZB_COND_LO 21

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define LZB_OP_AND 6'h21
`define LZB_OP_ANDN 6'h23
`define LZB_OP_ANDI 6'h29
`define LZB_OP_ANDNI 6'h2B
`define LZB_OP_BCC 6'h27
`define LZB_OP_BCCI 6'h2F
`define LZB_OP_IMM 6'h2C

// ----------------------------------------
// Branch conditions
// ----------------------------------------
`define LZB_CND_EQ 3'h0
`define LZB_CND_GT 3'h4
`define LZB_CND_GE 3'h5

// ----------------------------------------
// Latencies in cycles, and the PC step in bytes
// ----------------------------------------
`define LZB_LAT_ONE 2'h1
`define LZB_LAT_DLY 2'h2
`define LZB_LAT_NODLY 2'h3
`define LZB_PC_STEP 32'h0000_0004

`endif

//--- rtl/lzb_regfile.v
// Purpose: 32 x 32 register file, two read ports, one write port
// Assumes: read data registered; register zero reads as zero
// Notes: a write on the read edge is passed through to the read
`timescale 1ns/1ns
module lzb_regfile #(
    parameter WIDTH = 32,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    // Clock
    input wire ref_clk,
    // Write port
    input wire wrEn,
    input wire [AW-1:0] wrAddr,
    input wire [WIDTH-1:0] wrData,
    // Read ports
    input wire [AW-1:0] rdAddrA,
    input wire [AW-1:0] rdAddrB,
    output reg [WIDTH-1:0] rdDataA,
    output reg [WIDTH-1:0] rdDataB
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];

    // Read select: zero register forced, same-edge write passed through,
    // so a dependent op issued right after a write sees the new value
    function [WIDTH-1:0] rdSel;
        input [AW-1:0] addr;
        begin
            if (addr == {AW{1'b0}}) begin
                rdSel = {WIDTH{1'b0}};
            end else if (wrEn && addr == wrAddr) begin
                rdSel = wrData;
            end else begin
                rdSel = mem[addr];
            end
        end
    endfunction

    // Registered reads and the write port
    always @(posedge ref_clk) begin
        if (wrEn && wrAddr != {AW{1'b0}}) begin
            mem[wrAddr] <= wrData;
        end
        rdDataA <= rdSel(rdAddrA);
        rdDataB <= rdSel(rdAddrB);
    end

endmodule

//--- rtl/lzb_exec.v
// Purpose: executes AND family and zero-test branches
// Assumes: one instruction offered per instrValid, held until instrReady
// Notes: reads operands one cycle, then executes; branches may stall
// Notes on behaviour
// - AND of two registers into destination
// - AND with sign-extended literal, one cycle
// - AND with complemented second register
// - AND with complemented sign-extended literal
// - Literal sign-extends unless upper prefix precedes
// - Register branch: pc plus register, else four
// - Immediate branch: pc plus literal, else four
// - Equal branch taken when source is zero
// - Nonnegative branch taken when source at least zero
// - Positive branch taken when source above zero
// - Delay bit lets next instruction complete
// - Register branch costs one, two, three cycles
// - Immediate branch latency includes prediction outcome
// - Register format: opcode, three fields, zeros
// - Immediate format: literal in low sixteen bits
`timescale 1ns/1ns
`include "lzb_regs.vh"
module lzb_exec #(
    parameter RESET_PC = 32'h0000_0000
) (
    // Clock and reset
    input wire ref_clk,
    input wire reset,
    // Instruction stream
    input wire instrValid,
    input wire [31:0] instrWord,
    input wire predictTaken,
    output wire instrReady,
    // Architectural state
    output reg [31:0] pcOut_r,
    output reg carryFlag_r,
    output reg execDone_r,
    output reg [1:0] latency_r,
    output reg delaySlotOpen_r,
    output reg flushNext_r,
    output reg illegalOp_r,
    // Register file write port for checking
    output reg rfWrEn_r,
    output reg [4:0] rfWrAddr_r,
    output reg [31:0] rfWrData_r
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_EXEC = 3'b010;
    localparam ST_WAIT = 3'b100;

    reg [2:0] state_r, state_nxt;
    reg [31:0] instr_r;
    reg predict_r;
    reg [1:0] waitCnt_r, waitCnt_nxt;
    reg immPend_r;
    reg [15:0] immHigh_r;
    wire [31:0] opA, opB;

    // Condition test on signed source
    function condTrue;
        input [2:0] cond;
        input [31:0] val;
        begin
            case (cond)
                `LZB_CND_EQ: condTrue = (val == 32'h0000_0000);
                `LZB_CND_GE: condTrue = ~val[31];
                `LZB_CND_GT: condTrue = ~val[31] &&
                    (val != 32'h0000_0000);
                default: condTrue = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Operand fetch
    // ----------------------------------------
    lzb_regfile #(.WIDTH(32), .DEPTH(32), .AW(5)) u_lzb_regfile (
        .ref_clk(ref_clk),
        .wrEn(rfWrEn_r),
        .wrAddr(rfWrAddr_r),
        .wrData(rfWrData_r),
        .rdAddrA(instrWord[`LZB_RA_HI:`LZB_RA_LO]),
        .rdAddrB(instrWord[`LZB_RB_HI:`LZB_RB_LO]),
        .rdDataA(opA),
        .rdDataB(opB)
    );

    // ----------------------------------------
    // Decode of held instruction
    // ----------------------------------------
    wire [5:0] opc = instr_r[`LZB_OPC_HI:`LZB_OPC_LO];
    wire [4:0] rd = instr_r[`LZB_RD_HI:`LZB_RD_LO];
    wire [15:0] lit = instr_r[`LZB_IMM_HI:`LZB_IMM_LO];
    wire [31:0] immVal = immPend_r ? {immHigh_r, lit} :
        {{16{lit[15]}}, lit};
    wire dBit = instr_r[`LZB_DBIT];
    wire isBr = (opc == `LZB_OP_BCC) || (opc == `LZB_OP_BCCI);
    wire taken = condTrue(instr_r[`LZB_COND_HI:`LZB_COND_LO], opA);
    wire [31:0] brOff = (opc == `LZB_OP_BCCI) ? immVal : opB;
    reg [1:0] lat;

    // Branch latency selection
    always @* begin
        if (!taken) begin
            lat = (opc == `LZB_OP_BCCI && predict_r) ?
                `LZB_LAT_NODLY : `LZB_LAT_ONE;
        end else if (opc == `LZB_OP_BCCI && predict_r) begin
            lat = `LZB_LAT_ONE;
        end else begin
            lat = dBit ? `LZB_LAT_DLY : `LZB_LAT_NODLY;
        end
    end

    assign instrReady = (state_r == ST_IDLE);

    // Next state
    always @* begin
        state_nxt = state_r;
        waitCnt_nxt = waitCnt_r;
        case (state_r)
            ST_IDLE: begin
                if (instrValid) begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (isBr && lat != `LZB_LAT_ONE) begin
                    state_nxt = ST_WAIT;
                    waitCnt_nxt = lat - `LZB_LAT_ONE;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WAIT: begin
                waitCnt_nxt = waitCnt_r - 2'h1;
                if (waitCnt_r == 2'h1) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // Execute and state update
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            instr_r <= 32'h0000_0000;
            predict_r <= 1'b0;
            waitCnt_r <= 2'h0;
            immPend_r <= 1'b0;
            immHigh_r <= 16'h0000;
            pcOut_r <= RESET_PC;
            carryFlag_r <= 1'b0;
            execDone_r <= 1'b0;
            latency_r <= 2'h0;
            delaySlotOpen_r <= 1'b0;
            flushNext_r <= 1'b0;
            illegalOp_r <= 1'b0;
            rfWrEn_r <= 1'b0;
            rfWrAddr_r <= 5'h00;
            rfWrData_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            waitCnt_r <= waitCnt_nxt;
            execDone_r <= 1'b0;
            rfWrEn_r <= 1'b0;
            if (state_r == ST_IDLE && instrValid) begin
                instr_r <= instrWord;
                predict_r <= predictTaken;
            end
            // Carry flag is never written here
            carryFlag_r <= carryFlag_r;
            if (state_r == ST_EXEC) begin
                execDone_r <= 1'b1;
                latency_r <= isBr ? lat : `LZB_LAT_ONE;
                illegalOp_r <= 1'b0;
                immPend_r <= 1'b0;
                delaySlotOpen_r <= 1'b0;
                flushNext_r <= 1'b0;
                rfWrAddr_r <= rd;
                pcOut_r <= pcOut_r + `LZB_PC_STEP;
                case (opc)
                    `LZB_OP_AND: begin
                        rfWrEn_r <= 1'b1;
                        rfWrData_r <= opA & opB;
                    end
                    `LZB_OP_ANDN: begin
                        rfWrEn_r <= 1'b1;
                        rfWrData_r <= opA & ~opB;
                    end
                    `LZB_OP_ANDI: begin
                        rfWrEn_r <= 1'b1;
                        rfWrData_r <= opA & immVal;
                    end
                    `LZB_OP_ANDNI: begin
                        rfWrEn_r <= 1'b1;
                        rfWrData_r <= opA & ~immVal;
                    end
                    `LZB_OP_IMM: begin
                        immPend_r <= 1'b1;
                        immHigh_r <= lit;
                    end
                    `LZB_OP_BCC, `LZB_OP_BCCI: begin
                        if (taken) begin
                            pcOut_r <= pcOut_r + brOff;
                            delaySlotOpen_r <= dBit;
                            flushNext_r <= ~dBit;
                        end
                    end
                    default: illegalOp_r <= 1'b1;
                endcase
            end
        end
    end

endmodule

//--- tb/lzb_exec_monitor.sv
// Purpose: port checks of the AND and zero-branch slice
// Assumes: one clock, sync active-high reset
// Notes: attached by bind after the module
`timescale 1ns/1ns
module lzb_exec_monitor (
    // Clock and reset
    input wire ref_clk,
    input wire reset,
    // Handshake
    input wire instrValid,
    input wire instrReady,
    // Results
    input wire [31:0] pcOut_r,
    input wire carryFlag_r,
    input wire execDone_r,
    input wire [1:0] latency_r,
    input wire delaySlotOpen_r,
    input wire flushNext_r,
    input wire rfWrEn_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // --------------------------------
    // Assertions
    // --------------------------------
    chk_done_two_cycles: assert property (
        instrValid && instrReady |-> ##2 execDone_r)
        else $error("done not two cycles after accept");
    chk_done_pulse: assert property (
        execDone_r |=> !execDone_r)
        else $error("done held past one cycle");
    chk_ready_drops: assert property (
        instrValid && instrReady |=> !instrReady)
        else $error("ready high during execute");
    chk_carry_kept: assert property (
        1'b1 |=> $stable(carryFlag_r))
        else $error("carry flag changed");
    chk_pc_on_done: assert property (
        $changed(pcOut_r) |-> execDone_r)
        else $error("pc moved outside completion");
    chk_write_on_done: assert property (
        rfWrEn_r |-> execDone_r)
        else $error("register write without completion");
    chk_flags_apart: assert property (
        execDone_r |-> !(delaySlotOpen_r && flushNext_r))
        else $error("delay slot and flush both set");
    chk_slow_ready: assert property (
        execDone_r && latency_r == 2'h3
        |-> !instrReady ##1 !instrReady ##1 instrReady)
        else $error("three-cycle ready return wrong");
endmodule

bind lzb_exec lzb_exec_monitor u_lzb_exec_monitor (.ref_clk(ref_clk),
    .reset(reset), .instrValid(instrValid), .instrReady(instrReady),
    .pcOut_r(pcOut_r), .carryFlag_r(carryFlag_r),
    .execDone_r(execDone_r), .latency_r(latency_r),
    .delaySlotOpen_r(delaySlotOpen_r), .flushNext_r(flushNext_r),
    .rfWrEn_r(rfWrEn_r));

//--- tb/test_logic_and_zero_branch_exec.sv
// Purpose: self-checking bench of the AND and zero-branch slice
// Assumes: register file unreset; sources preloaded behind the core
// Notes: inputs change on the falling edge
`timescale 1ns/1ns
`include "lzb_regs.vh"
module test_logic_and_zero_branch_exec;
    // Bench signals
    reg ref_clk = 0;
    reg reset = 1;
    reg instrValid = 0;
    reg [31:0] instrWord = 0;
    reg predictTaken = 0;
    wire instrReady, carryFlag_r, execDone_r, delaySlotOpen_r;
    wire flushNext_r, illegalOp_r, rfWrEn_r;
    wire [1:0] latency_r;
    wire [4:0] rfWrAddr_r;
    wire [31:0] pcOut_r, rfWrData_r;
    integer failures = 0;
    integer tests_run = 0;
    reg [31:0] expPc = 0;
    lzb_exec u_lzb_exec (.ref_clk(ref_clk), .reset(reset),
        .instrValid(instrValid), .instrWord(instrWord),
        .predictTaken(predictTaken), .instrReady(instrReady),
        .pcOut_r(pcOut_r), .carryFlag_r(carryFlag_r),
        .execDone_r(execDone_r), .latency_r(latency_r),
        .delaySlotOpen_r(delaySlotOpen_r), .flushNext_r(flushNext_r),
        .illegalOp_r(illegalOp_r), .rfWrEn_r(rfWrEn_r),
        .rfWrAddr_r(rfWrAddr_r), .rfWrData_r(rfWrData_r));
    // ----------------------------
    // Helpers
    // ----------------------------
    task check(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    task conclude;
        begin
            if (failures == 0 && tests_run > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    function [31:0] rr(input [5:0] o, input [4:0] d, input [4:0] a,
                       input [4:0] b);
        rr = {o, d, a, b, 11'h000};
    endfunction
    function [31:0] ri(input [5:0] o, input [4:0] d, input [4:0] a,
                       input [15:0] i);
        ri = {o, d, a, i};
    endfunction
    // One instruction; fl 3 skips the branch flags
    task step(input [31:0] w, input p, input [31:0] nPc, input wr,
              input [31:0] data, input [1:0] lat, input [1:0] fl);
        integer c;
        integer doneAt;
        begin
            instrWord = w;
            predictTaken = p;
            instrValid = 1;
            @(negedge ref_clk);
            instrValid = 0;
            c = 0;
            doneAt = 0;
            while (c < 8 && (c == 0 || instrReady !== 1'b1)) begin
                @(negedge ref_clk);
                c = c + 1;
                if (execDone_r === 1'b1) begin
                    doneAt = c;
                    check(pcOut_r, nPc);
                    check(rfWrEn_r, wr);
                    check(latency_r, lat);
                    check(carryFlag_r, 0);
                    check(illegalOp_r, w[31:26] == 6'h3F);
                    if (wr) begin
                        check(rfWrAddr_r, w[25:21]);
                        check(rfWrData_r, data);
                    end
                    if (fl != 2'h3)
                        check({delaySlotOpen_r, flushNext_r}, fl);
                end
            end
            check(doneAt, 1);
            check(c, lat);
            expPc = nPc;
        end
    endtask
    // Result-writing instruction, one cycle, no branch flags
    task wrOp(input [31:0] w, input [31:0] data);
        begin
            step(w, 1'b0, expPc + 32'h0000_0004, 1'b1, data, 2'h1, 2'h3);
        end
    endtask
    // Instruction with no register write
    task noWrOp(input [31:0] w, input p, input [31:0] nPc,
                input [1:0] lat, input [1:0] fl);
        begin
            step(w, p, nPc, 1'b0, 32'h0000_0000, lat, fl);
        end
    endtask
    // ----------------------------
    // Scenarios
    // ----------------------------
    task t_logic;
        begin
            wrOp(rr(`LZB_OP_AND, 5'h05, 5'h01, 5'h02),
                32'h00F0_1200);
            wrOp(rr(`LZB_OP_ANDN, 5'h06, 5'h01, 5'h02),
                32'hF000_0034);
            // Reads the result written just before
            wrOp(ri(`LZB_OP_ANDI, 5'h07, 5'h06, 16'hFF0F),
                32'hF000_0004);
            wrOp(ri(`LZB_OP_ANDNI, 5'h08, 5'h01, 16'h8000),
                32'h0000_1234);
            noWrOp(ri(`LZB_OP_IMM, 5'h00, 5'h00, 16'h1234), 1'b0,
                expPc + 32'h0000_0004, 2'h1, 2'h3);
            wrOp(ri(`LZB_OP_ANDI, 5'h09, 5'h01, 16'h8001),
                32'h1030_0000);
            // Prefix used up: literal sign-extends again
            wrOp(ri(`LZB_OP_ANDI, 5'h0A, 5'h01, 16'h8001),
                32'hF0F0_0000);
            noWrOp(rr(6'h3F, 5'h00, 5'h00, 5'h00), 1'b0,
                expPc + 32'h0000_0004, 2'h1, 2'h3);
        end
    endtask
    task t_regbr;
        begin
            noWrOp(rr(`LZB_OP_BCC, 5'h00, 5'h00, 5'h03), 1'b0,
                expPc + 32'h0000_0020, 2'h3, 2'h1);
            noWrOp(rr(`LZB_OP_BCC, 5'h10, 5'h01, 5'h03), 1'b0,
                expPc + 32'h0000_0004, 2'h1, 2'h0);
            noWrOp(rr(`LZB_OP_BCC, 5'h05, 5'h02, 5'h04), 1'b0,
                expPc - 32'h0000_0010, 2'h3, 2'h1);
            noWrOp(rr(`LZB_OP_BCC, 5'h15, 5'h01, 5'h03), 1'b0,
                expPc + 32'h0000_0004, 2'h1, 2'h0);
            noWrOp(rr(`LZB_OP_BCC, 5'h14, 5'h02, 5'h03), 1'b0,
                expPc + 32'h0000_0020, 2'h2, 2'h2);
            noWrOp(rr(`LZB_OP_BCC, 5'h04, 5'h00, 5'h03), 1'b0,
                expPc + 32'h0000_0004, 2'h1, 2'h0);
            noWrOp(rr(`LZB_OP_BCC, 5'h15, 5'h00, 5'h04), 1'b0,
                expPc - 32'h0000_0010, 2'h2, 2'h2);
        end
    endtask
    task t_immbr;
        begin
            noWrOp(ri(`LZB_OP_BCCI, 5'h00, 5'h00, 16'hFFF8), 1'b0,
                expPc - 32'h0000_0008, 2'h3, 2'h1);
            noWrOp(ri(`LZB_OP_BCCI, 5'h15, 5'h02, 16'h0010), 1'b0,
                expPc + 32'h0000_0010, 2'h2, 2'h2);
            noWrOp(ri(`LZB_OP_BCCI, 5'h04, 5'h01, 16'h0040), 1'b0,
                expPc + 32'h0000_0004, 2'h1, 2'h0);
            noWrOp(ri(`LZB_OP_BCCI, 5'h00, 5'h00, 16'h0008), 1'b1,
                expPc + 32'h0000_0008, 2'h1, 2'h3);
            noWrOp(ri(`LZB_OP_BCCI, 5'h04, 5'h00, 16'h0008), 1'b1,
                expPc + 32'h0000_0004, 2'h3, 2'h0);
            noWrOp(ri(`LZB_OP_IMM, 5'h00, 5'h00, 16'h0001), 1'b0,
                expPc + 32'h0000_0004, 2'h1, 2'h3);
            noWrOp(ri(`LZB_OP_BCCI, 5'h10, 5'h00, 16'h0000), 1'b0,
                expPc + 32'h0001_0000, 2'h2, 2'h2);
        end
    endtask
    // ----------------------------
    // Clock, sequence, watchdog
    // ----------------------------
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        // Source values placed behind the core; no op can make them
        u_lzb_exec.u_lzb_regfile.mem[1] = 32'hF0F0_1234;
        u_lzb_exec.u_lzb_regfile.mem[2] = 32'h0FF0_FF00;
        u_lzb_exec.u_lzb_regfile.mem[3] = 32'h0000_0020;
        u_lzb_exec.u_lzb_regfile.mem[4] = 32'hFFFF_FFF0;
        reset = 0;
        check(pcOut_r, 0);
        check(instrReady, 1);
        t_logic;
        t_regbr;
        t_immbr;
        conclude;
    end
    initial begin
        #5000;
        failures = failures + 1;
        conclude;
    end
endmodule
